// ### src/bcmc_match.sv
// break channel 1 match condition logic with axi4-lite register slave
`include "bcmc_consts.svh"

module bcmc_match (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire bcmc_pkg::bcmc_bus_cycle_t bus_cycle,
  output logic                           channel_match,
  output logic                           irq
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // merge write data into a register under byte strobes and a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // true for a known register offset
  function automatic logic addr_ok(input logic [11:0] a);
    return (a == `BCMC_OFF_COND) || (a == `BCMC_OFF_CMP_DATA) || (a == `BCMC_OFF_CMP_MASK) ||
           (a == `BCMC_OFF_CNT_TGT) || (a == `BCMC_OFF_CNT_VAL) || (a == `BCMC_OFF_IRQ_STAT) ||
           (a == `BCMC_OFF_IRQ_MASK);
  endfunction

  // masked data compare: mask bit 1 means that bit is not compared
  function automatic logic data_eq(input logic [31:0] d, input logic [31:0] c,
                                   input logic [31:0] msk);
    return ((d ^ c) & ~msk) == 32'h00000000;
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0]            cond;
  logic [31:0]            cmp_data;
  logic [31:0]            cmp_mask;
  logic [`BCMC_CNT_W-1:0] cnt_tgt;
  logic [`BCMC_CNT_W-1:0] cnt_val;
  logic                   irq_stat;
  logic                   irq_mask;
  logic [31:0]            next_cond;
  logic [31:0]            next_cmp_data;
  logic [31:0]            next_cmp_mask;
  logic [`BCMC_CNT_W-1:0] next_cnt_tgt;
  logic [`BCMC_CNT_W-1:0] next_cnt_val;
  logic                   next_irq_stat;
  logic                   next_irq_mask;
  logic                   next_channel_match;
  logic [31:0]            tgt_wr;

  // write channel state: address and data held until both present
  logic                   aw_held;
  logic                   w_held;
  logic [11:0]            aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic [11:0]            next_aw_addr;
  logic [31:0]            next_w_data;
  logic [3:0]             next_w_strb;
  logic                   next_bvalid;
  logic [1:0]             next_bresp;
  logic                   wr_fire;

  // read channel state
  bcmc_pkg::bcmc_rd_state_t rd_state;
  bcmc_pkg::bcmc_rd_state_t next_rd_state;
  logic [31:0]              next_rdata;
  logic [1:0]               next_rresp;

  // ****************************************************************
  // match evaluation
  // ****************************************************************
  logic       ce;
  logic       fetch_ok;
  logic       oper_ok;
  logic       kind_ok;
  logic       asid_ok;
  logic       size_ok;
  logic       data_ok;
  logic       rw_ok;
  logic       cond_hit;
  logic [2:0] sz_sel;

  // combinational compare of the observed cycle against the condition
  always_comb begin
    sz_sel   = cond[`BCMC_SZ_HI:`BCMC_SZ_LO];
    ce       = cond[`BCMC_BIT_CE];
    fetch_ok = (cond[`BCMC_ID_HI:`BCMC_ID_LO] != 2'h2) && bus_cycle.is_fetch;
    oper_ok  = (cond[`BCMC_ID_HI:`BCMC_ID_LO] != 2'h1) && !bus_cycle.is_fetch;
    kind_ok  = fetch_ok || oper_ok;
    asid_ok  = !cond[`BCMC_BIT_AIE] ||
               (bus_cycle.asid == cond[`BCMC_AIV_HI:`BCMC_AIV_LO]);
    size_ok  = (sz_sel == 3'(bcmc_pkg::BCMC_SZ_ANY)) || (sz_sel == 3'(bus_cycle.size));
    if (!cond[`BCMC_BIT_DCE]) begin
      data_ok = 1'b1;
    end else if (bus_cycle.size == bcmc_pkg::BCMC_SZ_QUAD) begin
      data_ok = data_eq(bus_cycle.data[63:32], cmp_data, cmp_mask) &&
                data_eq(bus_cycle.data[31:0], cmp_data, cmp_mask);
    end else begin
      data_ok = data_eq(bus_cycle.data[31:0], cmp_data, cmp_mask);
    end
    rw_ok    = (cond[`BCMC_RW_HI:`BCMC_RW_LO] == 2'h1) ? !bus_cycle.is_write :
               (cond[`BCMC_RW_HI:`BCMC_RW_LO] == 2'h2) ? bus_cycle.is_write : 1'b1;
    cond_hit = ce && bus_cycle.valid && kind_ok && asid_ok &&
               (bus_cycle.is_fetch || (size_ok && data_ok && rw_ok));
  end

  // ****************************************************************
  // count and match pulse
  // ****************************************************************
  // counter restarts after each hit that reaches the target so the break repeats every target satisfactions
  always_comb begin
    next_cnt_val       = cnt_val;
    next_channel_match = 1'b0;
    if (cond_hit) begin
      if (cond[`BCMC_BIT_ECE]) begin
        if (cnt_val + `BCMC_CNT_W'(1) == cnt_tgt) begin
          next_channel_match = 1'b1;
          next_cnt_val       = '0;
        end else begin
          next_cnt_val = cnt_val + `BCMC_CNT_W'(1);
        end
      end else begin
        next_channel_match = 1'b1;
      end
    end
    if (wr_fire && aw_addr == `BCMC_OFF_CNT_VAL) begin
      next_cnt_val = '0;  // any write clears the count
    end
  end

  // ****************************************************************
  // register writes and interrupt
  // ****************************************************************
  // count target merged at full width, then cut to the counter width on purpose
  assign tgt_wr = merge({20'h00000, cnt_tgt}, w_data, w_strb, 32'h00000fff);
  always_comb begin
    next_cond     = cond;
    next_cmp_data = cmp_data;
    next_cmp_mask = cmp_mask;
    next_cnt_tgt  = cnt_tgt;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_fire) begin
      case (aw_addr)
        `BCMC_OFF_COND:     next_cond = merge(cond, w_data, w_strb, `BCMC_COND_WMASK);
        `BCMC_OFF_CMP_DATA: next_cmp_data = merge(cmp_data, w_data, w_strb, 32'hffffffff);
        `BCMC_OFF_CMP_MASK: next_cmp_mask = merge(cmp_mask, w_data, w_strb, 32'hffffffff);
        `BCMC_OFF_CNT_TGT:  next_cnt_tgt = tgt_wr[`BCMC_CNT_W-1:0];
        `BCMC_OFF_IRQ_MASK: if (w_strb[0]) next_irq_mask = w_data[0];
        `BCMC_OFF_IRQ_STAT: if (w_strb[0] && w_data[0]) next_irq_stat = 1'b0;
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    if (next_channel_match) begin
      next_irq_stat = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cond          <= `BCMC_COND_RESET;
      cmp_data      <= 32'h00000000;
      cmp_mask      <= 32'h00000000;
      cnt_tgt       <= '0;
      cnt_val       <= '0;
      irq_stat      <= 1'b0;
      irq_mask      <= 1'b0;
      channel_match <= 1'b0;
    end else begin
      cond          <= next_cond;
      cmp_data      <= next_cmp_data;
      cmp_mask      <= next_cmp_mask;
      cnt_tgt       <= next_cnt_tgt;
      cnt_val       <= next_cnt_val;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      channel_match <= next_channel_match;
    end
  end

  assign irq = irq_stat && irq_mask;  // level, high while unmasked event pending

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  // ready only while a slot is free; the response waits until bready
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = addr_ok(aw_addr) ? `BCMC_RESP_OKAY : `BCMC_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  assign s_axi_arready = (rd_state == bcmc_pkg::BCMC_RD_IDLE);
  assign s_axi_rvalid  = (rd_state == bcmc_pkg::BCMC_RD_RESP);

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    case (rd_state)
      bcmc_pkg::BCMC_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = bcmc_pkg::BCMC_RD_RESP;
          next_rresp    = addr_ok(s_axi_araddr) ? `BCMC_RESP_OKAY : `BCMC_RESP_SLVERR;
          case (s_axi_araddr)
            `BCMC_OFF_COND:     next_rdata = cond;
            `BCMC_OFF_CMP_DATA: next_rdata = cmp_data;
            `BCMC_OFF_CMP_MASK: next_rdata = cmp_mask;
            `BCMC_OFF_CNT_TGT:  next_rdata = {20'h00000, cnt_tgt};
            `BCMC_OFF_CNT_VAL:  next_rdata = {20'h00000, cnt_val};
            `BCMC_OFF_IRQ_STAT: next_rdata = {31'h00000000, irq_stat};
            `BCMC_OFF_IRQ_MASK: next_rdata = {31'h00000000, irq_mask};
            default:            next_rdata = 32'h00000000;
          endcase
        end
      end
      bcmc_pkg::BCMC_RD_RESP: begin
        if (s_axi_rready) begin
          next_rd_state = bcmc_pkg::BCMC_RD_IDLE;
        end
      end
      default: next_rd_state = bcmc_pkg::BCMC_RD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_state    <= bcmc_pkg::BCMC_RD_IDLE;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      rd_state    <= next_rd_state;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

// ### pkg/bcmc_consts.svh
// register offsets, field positions, reset values for the break channel match block
`ifndef BCMC_CONSTS_SVH
`define BCMC_CONSTS_SVH
`define BCMC_OFF_COND      12'h000
`define BCMC_OFF_CMP_DATA  12'h004
`define BCMC_OFF_CMP_MASK  12'h008
`define BCMC_OFF_CNT_TGT   12'h00c
`define BCMC_OFF_CNT_VAL   12'h010
`define BCMC_OFF_IRQ_STAT  12'h014
`define BCMC_OFF_IRQ_MASK  12'h018
`define BCMC_COND_RESET    32'h20000000
`define BCMC_COND_WMASK    32'hfffff8f7
`define BCMC_BIT_CE        0
`define BCMC_BIT_ECE       11
`define BCMC_BIT_DCE       15
`define BCMC_BIT_AIE       30
`define BCMC_SZ_HI         14
`define BCMC_SZ_LO         12
`define BCMC_AIV_HI        23
`define BCMC_AIV_LO        16
`define BCMC_ID_HI         5
`define BCMC_ID_LO         4
`define BCMC_RW_HI         2
`define BCMC_RW_LO         1
`define BCMC_CNT_W         12
`define BCMC_RESP_OKAY     2'h0
`define BCMC_RESP_SLVERR   2'h2
`endif

// ### pkg/bcmc_pkg.sv
// types shared by the break channel match block
package bcmc_pkg;
  typedef enum logic [2:0] {
    BCMC_SZ_ANY  = 3'h0,
    BCMC_SZ_BYTE = 3'h1,
    BCMC_SZ_WORD = 3'h2,
    BCMC_SZ_LONG = 3'h3,
    BCMC_SZ_QUAD = 3'h4
  } bcmc_size_t;

  // one observed cpu bus cycle
  typedef struct packed {
    logic        valid;
    logic        is_fetch;
    logic        is_write;
    logic [7:0]  asid;
    bcmc_size_t  size;
    logic [63:0] data;
  } bcmc_bus_cycle_t;

  typedef enum logic [1:0] {
    BCMC_RD_IDLE,
    BCMC_RD_RESP
  } bcmc_rd_state_t;
endpackage

// ### dv/bcmc_cpu_model.sv
// cpu bus model: offers one observed bus cycle while go is high
module bcmc_cpu_model (
  input  wire logic                      core_clk,
  input  wire logic                      go,
  input  wire bcmc_pkg::bcmc_bus_cycle_t cyc,
  output bcmc_pkg::bcmc_bus_cycle_t      bus_cycle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] last = 64'h0;
  // remember the last data so a released bus can show its inverse
  always @(posedge core_clk) begin
    if (go) last <= cyc.data;
  end
  // idle bus: valid low, data inverted so stale values never match by luck
  always_comb begin
    bus_cycle = cyc;
    if (!go) begin
      bus_cycle.valid = 1'b0;
      bus_cycle.data  = ~last;
    end
  end
endmodule

// ### dv/bcmc_match_props.sv
// port checker for the break channel match block
`include "bcmc_consts.svh"
module bcmc_match_props (
  input wire logic                      core_clk,
  input wire logic                      rst,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [11:0]               s_axi_araddr,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [31:0]               s_axi_rdata,
  input wire bcmc_pkg::bcmc_bus_cycle_t bus_cycle,
  input wire logic                      channel_match
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic rd_cond;
  // remember whether the read under way targets the condition register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) rd_cond <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) rd_cond <= (s_axi_araddr == `BCMC_OFF_COND);
  end
  match_cause_a: assert property (channel_match |-> $past(bus_cycle.valid))
    else $error("match pulse without an observed bus cycle");
  rsvd_zero_a: assert property (s_axi_rvalid && rd_cond |-> s_axi_rdata[10:8] == 3'h0)
    else $error("reserved condition bits read nonzero");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken with response pending");
  ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken with data pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule
bind bcmc_match bcmc_match_props i_bcmc_match_props (.core_clk, .rst, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bus_cycle, .channel_match);

// ### dv/testbench.sv
// self-checking bench for the break channel match block
`include "bcmc_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, go = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic channel_match, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  bcmc_pkg::bcmc_bus_cycle_t cyc = '0, bus_cycle;
  int compares = 0, miscompares = 0;
  // free running 100 MHz clock
  always #5 core_clk = ~core_clk;
  bcmc_match i_bcmc_match (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bus_cycle, .channel_match, .irq);
  bcmc_cpu_model i_bcmc_cpu_model (.core_clk, .go, .cyc, .bus_cycle);
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // axi write; address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        cmp("bresp", er, s_axi_bresp);
        return;
      end
    end
    miscompares++;
    final_report();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar;
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ar = s_axi_arvalid && s_axi_arready;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        cmp("rdata", ed, s_axi_rdata);
        cmp("rresp", er, s_axi_rresp);
        return;
      end
    end
    miscompares++;
    final_report();
  endtask
  // one observed cpu cycle, then the registered match pulse is judged
  task automatic send(input logic f, input logic [7:0] as, input logic [2:0] sz,
                      input logic [63:0] d, input logic em);
    @(posedge core_clk);
    cyc <= {1'b1, f, 1'b0, as, bcmc_pkg::bcmc_size_t'(sz), d};
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    cmp("channel_match", {31'h0, em}, {31'h0, channel_match});
  endtask
  // channel enabled condition word from its fields
  function automatic logic [31:0] cnd(logic ae, logic [7:0] av, logic de, logic [2:0] sz,
                                      logic ee, logic [1:0] id);
    return {1'b0, ae, 6'h0, av, de, sz, ee, 5'h00, id, 4'h1};
  endfunction
  localparam logic [11:0] C = `BCMC_OFF_COND;
  localparam logic [1:0] OK = `BCMC_RESP_OKAY;
  localparam logic [63:0] D = {2{32'h12345678}};
  task automatic t_regs();
    rd(C, `BCMC_COND_RESET, OK);
    wr(C, 32'hffffffff, OK);
    rd(C, `BCMC_COND_WMASK, OK);
    wr(12'h100, 32'h1, `BCMC_RESP_SLVERR);
    rd(12'h100, 32'h0, `BCMC_RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_match();
    wr(C, 32'hfffff8f6, OK);
    send(1'b1, 8'h00, 3'h1, D, 1'b0);
    wr(C, cnd(1'b1, 8'h5a, 1'b0, 3'h0, 1'b0, 2'h0), OK);
    send(1'b0, 8'h5a, 3'h3, D, 1'b1);
    send(1'b0, 8'h5b, 3'h3, D, 1'b0);
    wr(C, cnd(1'b0, 8'h5a, 1'b0, 3'h0, 1'b0, 2'h0), OK);
    send(1'b0, 8'h5b, 3'h3, D, 1'b1);
    for (int s = 1; s <= 4; s++) begin
      wr(C, cnd(1'b0, 8'h0, 1'b0, 3'(s), 1'b0, 2'h2), OK);
      send(1'b0, 8'h0, 3'(s), D, 1'b1);
      send(1'b0, 8'h0, 3'(s % 4 + 1), D, 1'b0);
    end
    wr(C, cnd(1'b0, 8'h0, 1'b0, 3'h1, 1'b0, 2'h0), OK);
    send(1'b1, 8'h0, 3'h3, D, 1'b1);
    wr(C, cnd(1'b0, 8'h0, 1'b0, 3'h0, 1'b0, 2'h2), OK);
    send(1'b0, 8'h0, 3'h4, D, 1'b1);
    $display("test match done");
  endtask
  task automatic t_data();
    wr(`BCMC_OFF_CMP_DATA, 32'h12345678, OK);
    wr(`BCMC_OFF_CMP_MASK, 32'h0, OK);
    wr(C, cnd(1'b0, 8'h0, 1'b1, 3'h4, 1'b0, 2'h2), OK);
    send(1'b0, 8'h0, 3'h4, D, 1'b1);
    send(1'b0, 8'h0, 3'h4, {32'h0, D[31:0]}, 1'b0);
    send(1'b0, 8'h0, 3'h4, {D[63:32], 32'h0}, 1'b0);
    wr(`BCMC_OFF_CMP_MASK, 32'h000000ff, OK);
    send(1'b0, 8'h0, 3'h4, {32'h12345600, 32'h123456ff}, 1'b1);
    wr(C, cnd(1'b0, 8'h0, 1'b0, 3'h4, 1'b0, 2'h2), OK);
    send(1'b0, 8'h0, 3'h4, 64'h0, 1'b1);
    wr(C, cnd(1'b0, 8'h0, 1'b1, 3'h4, 1'b0, 2'h0), OK);
    send(1'b1, 8'h0, 3'h1, 64'h0, 1'b1);
    $display("test data done");
  endtask
  task automatic t_count();
    wr(`BCMC_OFF_CNT_TGT, 32'h3, OK);
    wr(C, cnd(1'b0, 8'h0, 1'b0, 3'h0, 1'b1, 2'h0), OK);
    send(1'b0, 8'h0, 3'h1, D, 1'b0);
    send(1'b0, 8'h0, 3'h1, D, 1'b0);
    rd(`BCMC_OFF_CNT_VAL, 32'h2, OK);
    send(1'b0, 8'h0, 3'h1, D, 1'b1);
    rd(`BCMC_OFF_CNT_VAL, 32'h0, OK);
    $display("test count done");
  endtask
  task automatic t_irq();
    wr(`BCMC_OFF_IRQ_MASK, 32'h0, OK);
    wr(`BCMC_OFF_IRQ_STAT, 32'h1, OK);
    rd(`BCMC_OFF_IRQ_STAT, 32'h0, OK);
    wr(C, cnd(1'b0, 8'h0, 1'b0, 3'h0, 1'b0, 2'h0), OK);
    send(1'b0, 8'h0, 3'h2, D, 1'b1);
    cmp("irq masked", 32'h0, {31'h0, irq});
    rd(`BCMC_OFF_IRQ_STAT, 32'h1, OK);
    wr(`BCMC_OFF_IRQ_MASK, 32'h1, OK);
    cmp("irq raised", 32'h1, {31'h0, irq});
    wr(`BCMC_OFF_IRQ_STAT, 32'h1, OK);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_match();
    t_data();
    t_count();
    t_irq();
    final_report();
  end
endmodule
